/* cif_flag_logic.sv */
// Interrupt acceptance, processor flags and programmer-visible registers
`timescale 1ns/1ps
`default_nettype none
`include "cif_consts.svh"
module cif_flag_logic
    import cif_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ext_reset_n,
    input  wire logic        irq_req,
    input  wire logic [2:0]  irq_level,
    input  wire logic        swi_exec,
    input  wire logic [5:0]  swi_num,
    input  wire logic        reg_wr_en,
    input  wire logic [3:0]  reg_wr_sel,
    input  wire logic [19:0] reg_wr_data,
    input  wire logic [3:0]  reg_rd_sel,
    output logic [19:0]      reg_rd_data,
    output logic             irq_ack,
    output logic [2:0]       irq_ack_level,
    output logic             irq_pending,
    output logic [15:0]      flag_reg,
    output logic             int_enable,
    output logic             stack_sel,
    output logic [2:0]       processor_priority_level,
    output logic [15:0]      active_sp,
    output logic             core_in_reset
);
    // ==========================================================
    // External reset pin synchroniser
    logic [2:0] rpin_sync;
    logic       rpin_level;
    logic       next_rpin_level;

    always_comb begin
        next_rpin_level = rpin_level;
        // Second and third stage must agree before the level moves
        if (rpin_sync[1] == rpin_sync[2]) begin
            next_rpin_level = rpin_sync[2];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rpin_sync  <= 3'h0;
            rpin_level <= 1'b0;
        end else begin
            rpin_sync  <= {rpin_sync[1:0], ext_reset_n};
            rpin_level <= next_rpin_level;
        end
    end

    logic core_run;
    assign core_run = rpin_level;

    // ==========================================================
    // Register bank
    cif_bank_if bank_bus ();

    cif_reg_bank u_bank (
        .sys_clk (sys_clk),
        .rst     (rst),
        .bus     (bank_bus.bank)
    );

    cif_word_t flg;
    logic      wr_bank_sel;
    assign wr_bank_sel      = (reg_wr_sel <= CIF_SEL_FBASE);
    assign bank_bus.srst     = !core_run;
    assign bank_bus.bank_sel = flg[`CIF_FLG_BANK_BIT];
    assign bank_bus.wr_en    = reg_wr_en && wr_bank_sel && core_run;
    assign bank_bus.wr_idx   = reg_wr_sel[2:0];
    assign bank_bus.wr_data  = reg_wr_data[15:0];
    assign bank_bus.rd_idx   = reg_rd_sel[2:0];

    // ==========================================================
    // Flags and interrupt acceptance
    cif_word_t next_flg;
    logic      next_irq_ack;
    logic [2:0] next_ack_level;
    logic      next_pending;
    logic      hw_accept;
    logic [2:0] cur_prio;

    assign cur_prio = flg[`CIF_FLG_PRIO_MSB:`CIF_FLG_PRIO_LSB];
    // Software interrupt wins the cycle; the hardware request stays pending
    assign hw_accept = irq_req && flg[`CIF_FLG_IEN_BIT]
                       && (irq_level > cur_prio)
                       && !swi_exec;

    always_comb begin
        next_flg       = flg;
        next_irq_ack   = 1'b0;
        next_ack_level = irq_ack_level;
        next_pending   = irq_req && !hw_accept;
        if (reg_wr_en && reg_wr_sel == CIF_SEL_FLG) begin
            // Reserved bits are forced to zero on write
            next_flg = reg_wr_data[15:0] & `CIF_FLG_WR_MASK;
        end
        // Acknowledge overrides a software flag write in the same cycle
        if (swi_exec) begin
            next_flg[`CIF_FLG_IEN_BIT] = 1'b0;
            if (swi_num <= `CIF_SWI_SSEL_MAX) begin
                next_flg[`CIF_FLG_SSEL_BIT] = 1'b0;
            end
        end else if (hw_accept) begin
            next_flg[`CIF_FLG_IEN_BIT]  = 1'b0;
            next_flg[`CIF_FLG_SSEL_BIT] = 1'b0;
            next_flg[`CIF_FLG_PRIO_MSB:`CIF_FLG_PRIO_LSB] = irq_level;
            next_irq_ack   = 1'b1;
            next_ack_level = irq_level;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flg           <= `CIF_FLG_RESET;
            irq_ack       <= 1'b0;
            irq_ack_level <= 3'h0;
            irq_pending   <= 1'b0;
        end else if (!core_run) begin
            flg           <= `CIF_FLG_RESET;
            irq_ack       <= 1'b0;
            irq_ack_level <= 3'h0;
            irq_pending   <= 1'b0;
        end else begin
            flg           <= next_flg;
            irq_ack       <= next_irq_ack;
            irq_ack_level <= next_ack_level;
            irq_pending   <= next_pending;
        end
    end

    // ==========================================================
    // Remaining programmer-visible registers
    cif_addr_t pc;
    cif_addr_t intb;
    cif_word_t user_stack_pointer;
    cif_word_t interrupt_stack_pointer;
    cif_word_t sb;
    cif_addr_t next_pc;
    cif_addr_t next_intb;
    cif_word_t next_usp;
    cif_word_t next_isp;
    cif_word_t next_sb;
    cif_word_t next_active_sp;

    always_comb begin
        next_pc   = pc;
        next_intb = intb;
        next_usp  = user_stack_pointer;
        next_isp  = interrupt_stack_pointer;
        next_sb   = sb;
        if (reg_wr_en) begin
            unique case (reg_wr_sel)
                CIF_SEL_PC:   next_pc   = reg_wr_data;
                CIF_SEL_INTB: next_intb = reg_wr_data;
                CIF_SEL_USP:  next_usp  = reg_wr_data[15:0];
                CIF_SEL_ISP:  next_isp  = reg_wr_data[15:0];
                CIF_SEL_SB:   next_sb   = reg_wr_data[15:0];
                default: ;
            endcase
        end
        // Track the flag change of this same edge so the pointer never lags
        next_active_sp = next_flg[`CIF_FLG_SSEL_BIT] ? next_usp : next_isp;
    end

    // Read mux over all thirteen registers
    logic [19:0] next_rd_data;
    always_comb begin
        next_rd_data = 20'h00000;
        if (reg_rd_sel <= CIF_SEL_FBASE) begin
            next_rd_data = {4'h0, bank_bus.rd_data};
        end else begin
            unique case (reg_rd_sel)
                CIF_SEL_PC:   next_rd_data = pc;
                CIF_SEL_INTB: next_rd_data = intb;
                CIF_SEL_USP:  next_rd_data = {4'h0, user_stack_pointer};
                CIF_SEL_ISP:  next_rd_data = {4'h0, interrupt_stack_pointer};
                CIF_SEL_SB:   next_rd_data = {4'h0, sb};
                CIF_SEL_FLG:  next_rd_data = {4'h0, flg};
                default:      next_rd_data = 20'h00000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pc          <= `CIF_ADDR_RESET;
            intb        <= `CIF_ADDR_RESET;
            user_stack_pointer         <= `CIF_WORD_RESET;
            interrupt_stack_pointer         <= `CIF_WORD_RESET;
            sb          <= `CIF_WORD_RESET;
            active_sp   <= `CIF_WORD_RESET;
            reg_rd_data <= 20'h00000;
        end else if (!core_run) begin
            pc          <= `CIF_ADDR_RESET;
            intb        <= `CIF_ADDR_RESET;
            user_stack_pointer         <= `CIF_WORD_RESET;
            interrupt_stack_pointer         <= `CIF_WORD_RESET;
            sb          <= `CIF_WORD_RESET;
            active_sp   <= `CIF_WORD_RESET;
            reg_rd_data <= 20'h00000;
        end else begin
            pc          <= next_pc;
            intb        <= next_intb;
            user_stack_pointer         <= next_usp;
            interrupt_stack_pointer         <= next_isp;
            sb          <= next_sb;
            active_sp   <= next_active_sp;
            reg_rd_data <= next_rd_data;
        end
    end

    // Flag fields are plain bits of the flag flop
    assign flag_reg                 = flg;
    assign int_enable               = flg[`CIF_FLG_IEN_BIT];
    assign stack_sel                = flg[`CIF_FLG_SSEL_BIT];
    assign processor_priority_level = cur_prio;

    logic in_reset;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            in_reset <= 1'b1;
        end else begin
            in_reset <= !core_run;
        end
    end
    assign core_in_reset = in_reset;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_mask_blocks_req: assert property (
        (irq_req && !flg[`CIF_FLG_IEN_BIT]) |=> !irq_ack)
        else $error("masked request acknowledged");
    a_ack_clears_ien: assert property (
        irq_ack |-> !flg[`CIF_FLG_IEN_BIT])
        else $error("enable flag still set after acknowledge");
    a_active_sp_sel: assert property (
        core_run && $past(core_run) |-> active_sp == (flg[`CIF_FLG_SSEL_BIT] ? user_stack_pointer : interrupt_stack_pointer))
        else $error("active stack pointer does not follow select flag");
    a_ack_clears_ssel: assert property (
        irq_ack |-> !flg[`CIF_FLG_SSEL_BIT])
        else $error("stack select still set after acknowledge");
    a_swi_clears_ssel: assert property (
        (core_run && swi_exec && swi_num <= `CIF_SWI_SSEL_MAX) |=> !stack_sel && !int_enable)
        else $error("software interrupt left flags set");
    a_swi_high_keeps: assert property (
        (core_run && swi_exec && swi_num > `CIF_SWI_SSEL_MAX
         && !(reg_wr_en && reg_wr_sel == CIF_SEL_FLG)) |=> $stable(stack_sel))
        else $error("high software interrupt changed stack select");
    a_prio_not_above: assert property (
        (irq_req && irq_level <= cur_prio) |=> !irq_ack)
        else $error("request at or below level acknowledged");
    a_prio_accept: assert property (
        (core_run && irq_req && flg[`CIF_FLG_IEN_BIT] && irq_level > cur_prio && !swi_exec)
        |=> irq_ack && processor_priority_level == $past(irq_level)
            && irq_ack_level == $past(irq_level))
        else $error("eligible request not acknowledged with its level");
    a_rsvd_zero: assert property (
        flg[`CIF_FLG_RSVD_BIT] == 1'b0 && flg[11:8] == 4'h0)
        else $error("reserved flag bits set");
    a_pin_reset_hold: assert property (
        (!core_run) |=> flg == `CIF_FLG_RESET && !irq_ack && core_in_reset)
        else $error("core not held in reset");

    c_hw_ack:     cover property (irq_req ##1 irq_ack);
    c_swi_low:    cover property (swi_exec && swi_num <= `CIF_SWI_SSEL_MAX && stack_sel);
    c_pending:    cover property (irq_pending [*3] ##1 irq_ack);
    c_bank_swap:  cover property ($rose(flg[`CIF_FLG_BANK_BIT]));
endmodule : cif_flag_logic
`default_nettype wire

/* cif_consts.svh */
// Constants for the CPU interrupt flag and register bank logic
// Function
// - Maskable requests are blocked while the enable flag is 0, considered while 1.
// - Acknowledging an interrupt clears the enable flag to 0.
// - Stack-select flag 0 picks the interrupt stack, 1 the user stack.
// - Hardware acknowledge and software interrupts numbered 0 to 31 clear stack-select.
// - Processor priority level is a 3-bit field holding levels 0 to 7.
// - A request is taken only when its level is above the processor level.
// - Software writes 0 to the reserved flag bit; its read value is unchecked.
// - Thirteen programmer-visible registers, including the flag register.
// - Data, address and frame base registers form a bank with two copies.
// - Holding the external reset input low keeps the core in reset.
`ifndef CIF_CONSTS_SVH
`define CIF_CONSTS_SVH

// ==========================================================
// Flag register layout
`define CIF_FLG_BANK_BIT    4
`define CIF_FLG_IEN_BIT     6
`define CIF_FLG_SSEL_BIT    7
`define CIF_FLG_PRIO_LSB    12
`define CIF_FLG_PRIO_MSB    14
`define CIF_FLG_RSVD_BIT    15
`define CIF_FLG_WR_MASK     16'h70FF
`define CIF_FLG_RESET       16'h0000

// ==========================================================
// Reset values and limits
`define CIF_WORD_RESET      16'h0000
`define CIF_ADDR_RESET      20'h00000
`define CIF_SWI_SSEL_MAX    6'h1F
`define CIF_BANK_REGS       7
`define CIF_BANK_IDX_MAX    3'h6

`endif

/* cif_pkg.sv */
// Types shared by the CPU interrupt flag logic
package cif_pkg;
    typedef logic [15:0] cif_word_t;
    typedef logic [19:0] cif_addr_t;
    typedef enum logic [3:0] {
        CIF_SEL_DATA0 = 4'h0,
        CIF_SEL_DATA1 = 4'h1,
        CIF_SEL_DATA2 = 4'h2,
        CIF_SEL_DATA3 = 4'h3,
        CIF_SEL_ADDR0 = 4'h4,
        CIF_SEL_ADDR1 = 4'h5,
        CIF_SEL_FBASE = 4'h6,
        CIF_SEL_PC    = 4'h7,
        CIF_SEL_INTB  = 4'h8,
        CIF_SEL_USP   = 4'h9,
        CIF_SEL_ISP   = 4'hA,
        CIF_SEL_SB    = 4'hB,
        CIF_SEL_FLG   = 4'hC
    } cif_reg_sel_t;
endpackage : cif_pkg

/* cif_bank_if.sv */
// Carrier between the core and its register bank
`timescale 1ns/1ps
`default_nettype none
interface cif_bank_if;
    import cif_pkg::*;
    logic      srst;
    logic      bank_sel;
    logic      wr_en;
    logic [2:0] wr_idx;
    cif_word_t wr_data;
    logic [2:0] rd_idx;
    cif_word_t rd_data;
    modport core (output srst, output bank_sel, output wr_en, output wr_idx,
                  output wr_data, output rd_idx, input rd_data);
    modport bank (input srst, input bank_sel, input wr_en, input wr_idx,
                  input wr_data, input rd_idx, output rd_data);
endinterface : cif_bank_if
`default_nettype wire

/* cif_reg_bank.sv */
// Two copies of the data, address and frame base register bank
`timescale 1ns/1ps
`default_nettype none
`include "cif_consts.svh"
module cif_reg_bank
    import cif_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    cif_bank_if.bank  bus
);
    // ==========================================================
    // Storage
    cif_word_t regs      [2][`CIF_BANK_REGS];
    cif_word_t next_regs [2][`CIF_BANK_REGS];

    genvar b, r;
    generate
        for (b = 0; b < 2; b++) begin : g_bank
            for (r = 0; r < `CIF_BANK_REGS; r++) begin : g_reg
                always_comb begin
                    next_regs[b][r] = regs[b][r];
                    // Only the selected copy takes the write
                    if (bus.wr_en && (bus.bank_sel == 1'(b)) && (bus.wr_idx == 3'(r))) begin
                        next_regs[b][r] = bus.wr_data;
                    end
                end
                always_ff @(posedge sys_clk or posedge rst) begin
                    if (rst) begin
                        regs[b][r] <= `CIF_WORD_RESET;
                    end else if (bus.srst) begin
                        regs[b][r] <= `CIF_WORD_RESET;
                    end else begin
                        regs[b][r] <= next_regs[b][r];
                    end
                end
            end
        end
    endgenerate

    // Out-of-range index reads zero
    assign bus.rd_data = (bus.rd_idx <= `CIF_BANK_IDX_MAX) ?
                         regs[bus.bank_sel][bus.rd_idx] : `CIF_WORD_RESET;

    // ==========================================================
    // Checks
    a_bank_write_lands: assert property (@(posedge sys_clk) disable iff (rst)
        (bus.wr_en && !bus.srst && bus.wr_idx <= `CIF_BANK_IDX_MAX)
        |=> regs[$past(bus.bank_sel)][$past(bus.wr_idx)] == $past(bus.wr_data))
        else $error("bank write lost");
    a_bank_other_kept: assert property (@(posedge sys_clk) disable iff (rst)
        (bus.wr_en && !bus.srst && bus.wr_idx <= `CIF_BANK_IDX_MAX)
        |=> regs[!$past(bus.bank_sel)][$past(bus.wr_idx)]
            == $past(regs[!bus.bank_sel][bus.wr_idx]))
        else $error("write leaked into other bank");
endmodule : cif_reg_bank
`default_nettype wire

/* cif_irq_ctrl_model.sv */
// Behavioural model of the interrupt controller feeding prioritised requests
`timescale 1ns/1ps
`default_nettype none
module cif_irq_ctrl_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       raise,
    input  wire logic       withdraw,
    input  wire logic [2:0] level,
    input  wire logic       irq_ack,
    output logic            irq_req,
    output logic [2:0]      irq_level
);
    // ==========================================================
    // Request holder
    // Request stays up until acked; withdraw only where the bench orders it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_req   <= 1'b0;
            irq_level <= 3'h0;
        end else if (raise) begin
            irq_req   <= 1'b1;
            irq_level <= level;
        end else if (irq_ack || withdraw) begin
            irq_req   <= 1'b0;
            // Level is meaningless once released, so it must not linger
            irq_level <= ~irq_level;
        end
    end
endmodule : cif_irq_ctrl_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the interrupt flag logic
`timescale 1ns/1ps
`default_nettype none
`include "cif_consts.svh"
module testbench;
    import cif_pkg::*;
    // ==========================================================
    // Signals
    logic        sys_clk, rst, ext_reset_n, irq_req, swi_exec, reg_wr_en;
    logic        raise, withdraw, irq_ack, irq_pending, int_enable, stack_sel;
    logic        core_in_reset, seen;
    logic [2:0]  irq_level, lvl_in, irq_ack_level, processor_priority_level;
    logic [5:0]  swi_num;
    logic [3:0]  reg_wr_sel, reg_rd_sel;
    logic [19:0] reg_wr_data, reg_rd_data;
    logic [15:0] flag_reg, active_sp;
    int          fails, n_checks, i;
    // Reserved flag bits read back zero, yet they never enter a compare
    localparam logic [19:0] flg_keep = {4'h0, `CIF_FLG_WR_MASK};
    cif_flag_logic uut (.sys_clk(sys_clk), .rst(rst), .ext_reset_n(ext_reset_n),
        .irq_req(irq_req), .irq_level(irq_level), .swi_exec(swi_exec), .swi_num(swi_num),
        .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data),
        .reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data), .irq_ack(irq_ack),
        .irq_ack_level(irq_ack_level), .irq_pending(irq_pending), .flag_reg(flag_reg),
        .int_enable(int_enable), .stack_sel(stack_sel),
        .processor_priority_level(processor_priority_level), .active_sp(active_sp),
        .core_in_reset(core_in_reset));
    cif_irq_ctrl_model partner (.sys_clk(sys_clk), .rst(rst), .raise(raise),
        .withdraw(withdraw), .level(lvl_in), .irq_ack(irq_ack), .irq_req(irq_req),
        .irq_level(irq_level));
    // ==========================================================
    // Tasks
    task wrap_up;
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    task chk(input string name, input logic [19:0] exp, input logic [19:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask : chk
    // Reserved flag bits are written as zero and never compared
    task wr(input logic [3:0] sel, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr_en   <= 1'b1;
        reg_wr_sel  <= sel;
        reg_wr_data <= {4'h0, d};
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        #1;
    endtask : wr
    task rd_chk(input logic [3:0] sel, input logic [19:0] exp);
        @(posedge sys_clk);
        reg_rd_sel <= sel;
        @(posedge sys_clk);
        #1;
        chk("reg_rd_data", exp, reg_rd_data);
    endtask : rd_chk
    task wait_run(input logic v);
        int k;
        for (k = 0; k < 12 && core_in_reset !== v; k++) begin
            @(posedge sys_clk);
            #1;
        end
        if (core_in_reset !== v) begin
            $display("mismatch core_in_reset expected %b seen %b", v, core_in_reset);
            fails++;
            wrap_up();
        end
    endtask : wait_run
    task wait_ack;
        int k;
        seen = 1'b0;
        for (k = 0; k < 6 && !seen; k++) begin
            @(posedge sys_clk);
            #1;
            if (irq_ack === 1'b1) seen = 1'b1;
        end
    endtask : wait_ack
    task req(input logic [2:0] l);
        @(posedge sys_clk);
        raise  <= 1'b1;
        lvl_in <= l;
        @(posedge sys_clk);
        raise <= 1'b0;
        wait_ack();
    endtask : req
    task drop;
        @(posedge sys_clk);
        withdraw <= 1'b1;
        @(posedge sys_clk);
        withdraw <= 1'b0;
        #1;
    endtask : drop
    task flags(input logic ie, input logic ss, input logic [2:0] pl);
        chk("int_enable", {19'h0, ie}, {19'h0, int_enable});
        chk("stack_sel", {19'h0, ss}, {19'h0, stack_sel});
        chk("priority", {17'h0, pl}, {17'h0, processor_priority_level});
    endtask : flags
    // ==========================================================
    // Clock and sequence
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1'b1; ext_reset_n = 1'b1; swi_exec = 1'b0; swi_num = 6'h00;
        reg_wr_en = 1'b0; reg_wr_sel = 4'h0; reg_wr_data = 20'h00000; reg_rd_sel = 4'h0;
        raise = 1'b0; withdraw = 1'b0; lvl_in = 3'h0; fails = 0; n_checks = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        wait_run(1'b0);
        chk("flag_reg", 20'h00000, {4'h0, flag_reg} & flg_keep);
        // Stack pointer choice
        wr(CIF_SEL_USP, 16'h1234);
        wr(CIF_SEL_ISP, 16'h5678);
        wr(CIF_SEL_FLG, 16'h0080);
        chk("active_sp", 20'h01234, {4'h0, active_sp});
        wr(CIF_SEL_FLG, 16'h0000);
        chk("active_sp", 20'h05678, {4'h0, active_sp});
        // Masked request waits, then is taken once enabled
        wr(CIF_SEL_FLG, 16'h0080);
        req(3'h7);
        chk("irq_ack", 20'h00000, {19'h0, seen});
        chk("irq_pending", 20'h00001, {19'h0, irq_pending});
        // Still-pending request is taken as soon as the enable lands
        wr(CIF_SEL_FLG, 16'h00C0);
        wait_ack();
        chk("irq_ack", 20'h00001, {19'h0, seen});
        flags(1'b0, 1'b0, 3'h7);
        // Priority compare over every level against level 3
        for (i = 0; i < 8; i++) begin
            wr(CIF_SEL_FLG, 16'h30C0);
            req(i[2:0]);
            chk("irq_ack", {19'h0, i > 3}, {19'h0, seen});
            if (i > 3) begin
                flags(1'b0, 1'b0, i[2:0]);
                chk("ack_level", {17'h0, i[2:0]}, {17'h0, irq_ack_level});
                chk("active_sp", 20'h05678, {4'h0, active_sp});
            end else begin
                chk("irq_pending", 20'h00001, {19'h0, irq_pending});
                drop();
            end
        end
        // Software interrupts at the number boundaries
        for (i = 0; i < 4; i++) begin
            wr(CIF_SEL_FLG, 16'h30C0);
            @(posedge sys_clk);
            swi_exec <= 1'b1;
            swi_num  <= (i == 0) ? 6'h00 : (i == 1) ? 6'h1F : (i == 2) ? 6'h20 : 6'h3F;
            @(posedge sys_clk);
            swi_exec <= 1'b0;
            #1;
            flags(1'b0, i > 1, 3'h3);
        end
        // Two copies of the bank
        wr(CIF_SEL_FLG, 16'h0000);
        for (i = 0; i < 7; i++) wr(i[3:0], 16'h1100 + i[15:0]);
        wr(CIF_SEL_FLG, 16'h0010);
        for (i = 0; i < 7; i++) wr(i[3:0], 16'h2200 + i[15:0]);
        for (i = 0; i < 7; i++) rd_chk(i[3:0], 20'h02200 + i[19:0]);
        wr(CIF_SEL_FLG, 16'h0000);
        for (i = 0; i < 7; i++) rd_chk(i[3:0], 20'h01100 + i[19:0]);
        rd_chk(CIF_SEL_USP, 20'h01234);
        rd_chk(CIF_SEL_ISP, 20'h05678);
        wr(CIF_SEL_PC, 16'hBEEF);
        wr(CIF_SEL_INTB, 16'h4321);
        wr(CIF_SEL_SB, 16'h9ABC);
        rd_chk(CIF_SEL_PC, 20'h0BEEF);
        rd_chk(CIF_SEL_INTB, 20'h04321);
        rd_chk(CIF_SEL_SB, 20'h09ABC);
        wr(CIF_SEL_FLG, 16'h30C5);
        @(posedge sys_clk);
        reg_rd_sel <= CIF_SEL_FLG;
        @(posedge sys_clk);
        #1;
        chk("reg_rd_data", 20'h030C5 & flg_keep, reg_rd_data & flg_keep);
        // Reset pin held low
        @(posedge sys_clk);
        ext_reset_n <= 1'b0;
        wait_run(1'b1);
        wr(CIF_SEL_FLG, 16'h00C0);
        chk("flag_reg", 20'h00000, {4'h0, flag_reg} & flg_keep);
        @(posedge sys_clk);
        ext_reset_n <= 1'b1;
        wait_run(1'b0);
        flags(1'b0, 1'b0, 3'h0);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
